// ### src/lps_sync_ctrl.sv
// Function
// - gate on, LIN mode: hold UART receive high until synced
// - gate off: pass UART receive through
// - pulse read: rising edge sets break status
// - break timer runs falling to rising edge
// - compare match and overflow raise interrupts
// - pulse write: no break status on rise
// - pulse write: break timer still stops on rise
// - stop edge bit picks rising or falling count
// - mode bit selects pulse bus or LIN
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_sync_ctrl
#(
  parameter int CNT_W         = 20,
  parameter int BREAK_MIN_CYC = `LPS_BREAK_MIN_CYC
)
(
  input  wire logic        pclk,      // system clock
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb enable
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error, unmapped address
  input  wire logic        bus_pin,   // single-wire bus receive level
  output logic             uart_rxd,  // receive line towards the UART
  output logic             irq        // level interrupt
);

  localparam logic [CNT_W-1:0] BRK_MIN = CNT_W'(BREAK_MIN_CYC);

  // apb register select
  function automatic logic [5:0] reg_sel(input logic [7:0] a);
    reg_sel = '0;
    unique case (a)
      `LPS_OFF_CTRL:    reg_sel[0] = 1'b1;
      `LPS_OFF_EDGE:    reg_sel[1] = 1'b1;
      `LPS_OFF_STAT:    reg_sel[2] = 1'b1;
      `LPS_OFF_MASK:    reg_sel[3] = 1'b1;
      `LPS_OFF_BRKVAL:  reg_sel[4] = 1'b1;
      `LPS_OFF_SYNCVAL: reg_sel[5] = 1'b1;
      default:          reg_sel    = '0;
    endcase
  endfunction

  lps_pkg::lps_edge_s  bus;
  lps_pkg::lps_ctrl_s  ctrl_q;
  lps_pkg::lps_ctrl_s  ctrl_d;
  logic [3:0]          edge_cfg_q;
  logic [3:0]          edge_cfg_d;
  logic [3:0]          stat_q;
  logic [3:0]          stat_d;
  logic [3:0]          mask_q;
  logic [3:0]          mask_d;
  logic [CNT_W-1:0]    cmp_q;
  logic [CNT_W-1:0]    cmp_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  lps_pkg::lps_lin_e   st_q;
  lps_pkg::lps_lin_e   st_d;
  logic [CNT_W-1:0]    sync_cnt_q;
  logic [CNT_W-1:0]    sync_cnt_d;
  logic [3:0]          rcnt_q;
  logic [3:0]          rcnt_d;
  logic [3:0]          fcnt_q;
  logic [3:0]          fcnt_d;
  logic [5:0]          sel;
  logic                wr;
  logic                rd_setup;
  logic [CNT_W-1:0]    brk_cnt;
  logic                brk_run;
  logic                brk_cmp;
  logic                brk_ovf;
  logic                pulse_mode;
  logic                break_seen;
  logic                sync_hit;
  logic [3:0]          stat_set;
  logic [3:0]          stat_clr;

  lps_edge_sync u_sync
  (
    .clk    (pclk),
    .rst_n  (presetn),
    .pin    (bus_pin),
    .edge_o (bus)
  );

  lps_break_timer #(.W(CNT_W)) u_brk
  (
    .clk     (pclk),
    .rst_n   (presetn),
    .start   (bus.fall && ctrl_q.enable),
    .stop    (bus.rise),
    .cmp_val (cmp_q),
    .count   (brk_cnt),
    .running (brk_run),
    .cmp_evt (brk_cmp),
    .ovf_evt (brk_ovf)
  );

  assign pulse_mode = ctrl_q.enable && (ctrl_q.mode == lps_pkg::LPS_MODE_PULSE);
  // a LIN break is a low pulse at least the minimum length
  assign break_seen = ctrl_q.enable && !pulse_mode && bus.rise && brk_run
                      && (brk_cnt >= BRK_MIN);

  // ---------------- apb slave ----------------
  assign sel      = reg_sel(paddr);
  assign wr       = psel && penable && pwrite && (sel != '0);
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (sel == '0);
  assign prdata   = rdata_q;

  always_comb
  begin
    ctrl_d     = ctrl_q;
    edge_cfg_d = edge_cfg_q;
    mask_d     = mask_q;
    cmp_d      = cmp_q;
    stat_clr   = '0;
    rdata_d    = rdata_q;
    if (wr && sel[0])
    begin
      ctrl_d.enable    = pwdata[`LPS_CTRL_EN_BIT];
      ctrl_d.mode      = lps_pkg::lps_mode_e'(pwdata[`LPS_CTRL_MODE_BIT]);
      ctrl_d.stop_rise = pwdata[`LPS_CTRL_STOP_BIT];
      ctrl_d.gate      = pwdata[`LPS_CTRL_GATE_BIT];
    end
    if (wr && sel[1])
      edge_cfg_d = pwdata[`LPS_EDGE_MSB:`LPS_EDGE_LSB];
    if (wr && sel[2])
      stat_clr = pwdata[3:0];
    if (wr && sel[3])
      mask_d = pwdata[3:0];
    if (wr && sel[4])
      cmp_d = pwdata[CNT_W-1:0];
    if (rd_setup)
    begin
      rdata_d = '0;
      if (sel[0])
      begin
        rdata_d[`LPS_CTRL_EN_BIT]   = ctrl_q.enable;
        rdata_d[`LPS_CTRL_MODE_BIT] = ctrl_q.mode;
        rdata_d[`LPS_CTRL_STOP_BIT] = ctrl_q.stop_rise;
        rdata_d[`LPS_CTRL_GATE_BIT] = ctrl_q.gate;
      end
      if (sel[1])
        rdata_d[`LPS_EDGE_MSB:`LPS_EDGE_LSB] = edge_cfg_q;
      if (sel[2])
        rdata_d[3:0] = stat_q;
      if (sel[3])
        rdata_d[3:0] = mask_q;
      if (sel[4])
        rdata_d[CNT_W-1:0] = brk_cnt;
      if (sel[5])
        rdata_d[CNT_W-1:0] = sync_cnt_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= lps_pkg::lps_ctrl_s'(`LPS_CTRL_RST);
      edge_cfg_q <= `LPS_EDGE_RST;
      mask_q     <= `LPS_MASK_RST;
      cmp_q      <= '0;
      rdata_q    <= '0;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      edge_cfg_q <= edge_cfg_d;
      mask_q     <= mask_d;
      cmp_q      <= cmp_d;
      rdata_q    <= rdata_d;
    end
  end

  // ---------------- LIN break / sync tracking ----------------
  always_comb
  begin
    st_d       = st_q;
    sync_cnt_d = sync_cnt_q;
    rcnt_d     = rcnt_q;
    fcnt_d     = fcnt_q;
    sync_hit   = 1'b0;
    if (!ctrl_q.enable || pulse_mode)
      st_d = lps_pkg::LPS_HUNT;
    else if (break_seen)
    begin
      st_d       = lps_pkg::LPS_SYNC;
      sync_cnt_d = '0;
      rcnt_d     = '0;
      fcnt_d     = '0;
    end
    else
    begin
      unique case (st_q)
        lps_pkg::LPS_HUNT:
          st_d = lps_pkg::LPS_HUNT;
        lps_pkg::LPS_SYNC:
        begin
          // timer starts at the first falling edge of the sync byte
          if (fcnt_q != '0)
            sync_cnt_d = sync_cnt_q + 1'b1;
          if (bus.rise)
            rcnt_d = rcnt_q + 1'b1;
          if (bus.fall)
            fcnt_d = fcnt_q + 1'b1;
          if (ctrl_q.stop_rise ? (bus.rise && rcnt_d == edge_cfg_q)
                               : (bus.fall && fcnt_d == edge_cfg_q))
          begin
            sync_hit = 1'b1;
            st_d     = lps_pkg::LPS_PASS;
          end
        end
        lps_pkg::LPS_PASS:
          st_d = lps_pkg::LPS_PASS;
        default:
          st_d = lps_pkg::LPS_HUNT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= lps_pkg::LPS_HUNT;
      sync_cnt_q <= '0;
      rcnt_q     <= '0;
      fcnt_q     <= '0;
    end
    else
    begin
      st_q       <= st_d;
      sync_cnt_q <= sync_cnt_d;
      rcnt_q     <= rcnt_d;
      fcnt_q     <= fcnt_d;
    end
  end

  // receive gating towards the UART, registered
  logic rxd_q;
  logic rxd_d;

  always_comb
  begin
    if (ctrl_q.enable && !pulse_mode && ctrl_q.gate && (st_q != lps_pkg::LPS_PASS))
      rxd_d = 1'b1;
    else
      rxd_d = bus.lvl;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxd_q <= 1'b1;
    else
      rxd_q <= rxd_d;
  end

  assign uart_rxd = rxd_q;

  // ---------------- status and interrupt ----------------
  always_comb
  begin
    stat_set = '0;
    stat_set[`LPS_ST_BRK]  = (pulse_mode && ctrl_q.gate && bus.rise)
                             || break_seen;
    stat_set[`LPS_ST_BCMP] = brk_cmp;
    stat_set[`LPS_ST_BOVF] = brk_ovf;
    stat_set[`LPS_ST_SYNC] = sync_hit;
    // a set in the same cycle as its clear wins
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= `LPS_ST_RST;
    else
      stat_q <= stat_d;
  end

  logic irq_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_d & mask_d);
  end

  assign irq = irq_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gate_hold;
    ctrl_q.enable && !pulse_mode && ctrl_q.gate && st_q != lps_pkg::LPS_PASS
      |=> uart_rxd;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("rx not held high");

  property p_gate_pass;
    !ctrl_q.gate |=> uart_rxd == $past(bus.lvl);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("rx not passed");

  property p_pulse_brk;
    pulse_mode && ctrl_q.gate && bus.rise
      |=> stat_q[`LPS_ST_BRK] && (irq || !mask_q[`LPS_ST_BRK]);
  endproperty
  a_pulse_brk: assert property (p_pulse_brk) else $error("no break status on rise");

  sequence s_restart;
    brk_cnt == '0 ##1 brk_cnt == CNT_W'(1);
  endsequence
  property p_timer_restart;
    ctrl_q.enable && bus.fall ##1 !bus.rise |-> s_restart;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("no restart");

  property p_timer_hold;
    !brk_run && !(bus.fall && ctrl_q.enable) |=> $stable(brk_cnt);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("held count moved");

  property p_write_stop;
    pulse_mode && !ctrl_q.gate && bus.rise |=> !brk_run;
  endproperty
  a_write_stop: assert property (p_write_stop) else $error("timer not stopped");

  property p_no_brk;
    pulse_mode && !ctrl_q.gate && bus.rise && !stat_q[0] |=> !stat_q[`LPS_ST_BRK];
  endproperty
  a_no_brk: assert property (p_no_brk) else $error("break status in write mode");

  property p_cmp;
    brk_run && !bus.rise && brk_cnt == cmp_q |=> stat_q[`LPS_ST_BCMP];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare not flagged");

  property p_ovf;
    brk_run && !bus.rise && &brk_cnt |=> stat_q[`LPS_ST_BOVF] && !brk_run;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_sync_stop;
    st_q == lps_pkg::LPS_SYNC && !break_seen && ctrl_q.stop_rise && bus.rise
      && rcnt_q + 4'h1 == edge_cfg_q |=> st_q == lps_pkg::LPS_PASS && stat_q[3];
  endproperty
  a_sync_stop: assert property (p_sync_stop) else $error("sync not stopped");

  property p_mode;
    pulse_mode |=> st_q == lps_pkg::LPS_HUNT;
  endproperty
  a_mode: assert property (p_mode) else $error("LIN tracking in pulse mode");

endmodule

// ### src/lps_consts.svh
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// register byte offsets
`define LPS_OFF_CTRL     8'h00
`define LPS_OFF_EDGE     8'h04
`define LPS_OFF_STAT     8'h08
`define LPS_OFF_MASK     8'h0C
`define LPS_OFF_BRKVAL   8'h10
`define LPS_OFF_SYNCVAL  8'h14

// control register fields
`define LPS_CTRL_EN_BIT    2
`define LPS_CTRL_MODE_BIT  6
`define LPS_CTRL_STOP_BIT  7
`define LPS_CTRL_GATE_BIT  8
`define LPS_CTRL_RST       4'h0

// edge configuration field [7:4]
`define LPS_EDGE_LSB       4
`define LPS_EDGE_MSB       7
`define LPS_EDGE_RST       4'h0

// status / mask bits
`define LPS_ST_BRK         0
`define LPS_ST_BCMP        1
`define LPS_ST_BOVF        2
`define LPS_ST_SYNC        3
`define LPS_ST_RST         4'h0
`define LPS_MASK_RST       4'h0

// timing
`define LPS_CLK_NS         8
`define LPS_BREAK_MIN_NS   677000
`define LPS_BREAK_MIN_CYC  (`LPS_BREAK_MIN_NS / `LPS_CLK_NS)

`endif

// ### src/lps_pkg.sv
package lps_pkg;

  typedef enum logic {
    LPS_MODE_LIN   = 1'b0,
    LPS_MODE_PULSE = 1'b1
  } lps_mode_e;

  typedef enum logic [1:0] {
    LPS_HUNT = 2'b00,
    LPS_SYNC = 2'b01,
    LPS_PASS = 2'b10
  } lps_lin_e;

  typedef struct packed {
    logic      gate;
    logic      stop_rise;
    lps_mode_e mode;
    logic      enable;
  } lps_ctrl_s;

  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } lps_edge_s;

endpackage

// ### src/lps_edge_sync.sv
`timescale 1ns/1ps
module lps_edge_sync
(
  input  wire logic              clk,     // system clock
  input  wire logic              rst_n,   // async reset, active low
  input  wire logic              pin,     // raw bus level
  output lps_pkg::lps_edge_s     edge_o   // synchronised level and edges
);

  logic s1_q;
  logic s2_q;
  logic prev_q;

  // bus idles high, so the chain resets high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  always_comb
  begin
    edge_o.lvl  = s2_q;
    edge_o.rise = s2_q & ~prev_q;
    edge_o.fall = ~s2_q & prev_q;
  end

endmodule

// ### src/lps_break_timer.sv
`timescale 1ns/1ps
module lps_break_timer
#(
  parameter int W = 20
)
(
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic         start,    // falling edge: restart from zero
  input  wire logic         stop,     // rising edge: freeze count
  input  wire logic [W-1:0] cmp_val,  // compare value
  output logic      [W-1:0] count,    // running or held count
  output logic              running,  // timer is counting
  output logic              cmp_evt,  // one-cycle compare match
  output logic              ovf_evt   // one-cycle overflow
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;
  logic         full;

  always_comb
  begin
    full    = &cnt_q;
    cnt_d   = cnt_q;
    run_d   = run_q;
    cmp_evt = run_q && !stop && (cnt_q == cmp_val);
    ovf_evt = run_q && !stop && full;
    if (start)
    begin
      cnt_d = '0;
      run_d = 1'b1;
    end
    else if (stop || (run_q && full))
      run_d = 1'b0;
    else if (run_q)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign count   = cnt_q;
  assign running = run_q;

endmodule

// ### sim/lps_bus_node.sv
`timescale 1ns/1ps
module lps_bus_node
(
  input  wire logic clk,     // system clock
  output logic      bus_pin  // bus level, pulled high when released
);
  initial bus_pin = 1'b1;

  // hold the bus low for n cycles, then release it to the pull-up level
  task automatic pulse(input int n);
    begin
      @(posedge clk);
      bus_pin <= 1'b0;
      repeat (n) @(posedge clk);
      bus_pin <= 1'b1;
    end
  endtask

  // start bit, eight data bits lsb first, stop bit; bt cycles a bit
  task automatic frame(input logic [7:0] b, input int bt);
    logic [9:0] sh;
    begin
      sh = {1'b1, b, 1'b0};
      @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
        bus_pin <= sh[i];
        repeat (bt) @(posedge clk);
      end
    end
  endtask
endmodule

// ### sim/test_lps_sync_ctrl.sv
`timescale 1ns/1ps
module test_lps_sync_ctrl;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_pin;
  logic        uart_rxd;
  logic        irq;
  int          err_total;
  int          total_checks;
  logic [31:0] exp_q[$];
  int          tol_q[$];
  logic [31:0] lfsr;

  lps_sync_ctrl #(.CNT_W(8), .BREAK_MIN_CYC(40)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_pin(bus_pin),
    .uart_rxd(uart_rxd), .irq(irq)
  );

  lps_bus_node node (.clk(pclk), .bus_pin(bus_pin));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd(input logic [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] ev, input int tol);
    logic bad;
    begin
      total_checks++;
      bad = (got !== ev);
      if (tol > 0 && ^got !== 1'bx && got + tol >= ev && got <= ev + tol)
        bad = 1'b0;
      if (bad)
      begin
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, ev);
      end
    end
  endtask

  task automatic tally_and_finish();
    begin
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // for reads d is the expected data, noted for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input int tol = 0);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      if (!w)
      begin
        exp_q.push_back(d);
        tol_q.push_back(tol);
      end
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic pins(input logic rx, input logic ir);
    begin
      @(negedge pclk);
      chk({31'h0, uart_rxd}, {31'h0, rx}, 0);
      chk({31'h0, irq}, {31'h0, ir}, 0);
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      chk(prdata, exp_q.pop_front(), tol_q.pop_front());
      chk({31'h0, pslverr}, {31'h0, (paddr == 8'h18)}, 0);
    end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    int w;
    logic [9:0] fr;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    lfsr = 32'h0DCDC85B;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    pins(1'b1, 1'b0);
    for (int a = 0; a < 8'h1C; a += 4)
      apb(1'b0, a[7:0], 32'h0);
    lfsr = rnd(lfsr);
    apb(1'b1, 8'h0C, {lfsr[31:4], 4'hF});
    apb(1'b1, 8'h10, {lfsr[31:8], 8'h0A});
    apb(1'b1, 8'h00, 32'h144);
    repeat (3)
    begin
      lfsr = rnd(lfsr);
      w = 12 + int'(lfsr[5:0]);
      node.pulse(w);
      settle();
      pins(1'b1, 1'b1);
      apb(1'b0, 8'h08, 32'h3);
      apb(1'b0, 8'h10, 32'(w), 1);
      apb(1'b1, 8'h08, 32'h3);
      pins(1'b1, 1'b0);
    end
    apb(1'b1, 8'h00, 32'h44);
    node.pulse(30);
    settle();
    apb(1'b0, 8'h08, 32'h2);
    apb(1'b0, 8'h10, 32'd30, 1);
    apb(1'b1, 8'h08, 32'hF);
    apb(1'b1, 8'h0C, 32'h0);
    node.pulse(300);
    settle();
    apb(1'b0, 8'h08, 32'h6);
    pins(1'b1, 1'b0);
    apb(1'b0, 8'h10, 32'hFF);
    apb(1'b1, 8'h08, 32'hF);
    apb(1'b1, 8'h04, 32'h50);
    apb(1'b1, 8'h00, 32'h184);
    node.pulse(50);
    fork
      node.frame(8'h55, 8);
      begin
        repeat (6) @(posedge pclk);
        pins(1'b1, 1'b0);
      end
    join
    settle();
    apb(1'b0, 8'h08, 32'hB);
    apb(1'b0, 8'h14, 32'd72);
    apb(1'b1, 8'h08, 32'hF);
    lfsr = rnd(lfsr);
    // a set bit 4 keeps every low run below the break length
    fr = {1'b1, lfsr[7:0] | 8'h10, 1'b0};
    fork
      node.frame(fr[8:1], 8);
      begin
        @(posedge pclk);
        for (int i = 0; i < 10; i++)
        begin
          repeat (6) @(posedge pclk);
          pins(fr[i], 1'b0);
          repeat (2) @(posedge pclk);
        end
      end
    join
    fork
      node.pulse(20);
      begin
        repeat (8) @(posedge pclk);
        pins(1'b0, 1'b0);
      end
    join
    settle();
    apb(1'b0, 8'h08, 32'h2);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'hF);
    apb(1'b1, 8'h00, 32'h4);
    fork
      node.pulse(50);
      begin
        repeat (8) @(posedge pclk);
        pins(1'b0, 1'b0);
      end
    join
    node.frame(8'h55, 8);
    settle();
    apb(1'b0, 8'h08, 32'hB);
    apb(1'b0, 8'h14, 32'd64);
    tally_and_finish();
  end
endmodule
